/* verification/pin_drive_protect_config_monitor.sv */
/* Port checker for the pin role, drive and protect register.
   Assumes one clock domain and an active-low asynchronous reset. */
`timescale 1ns/1ns
module pin_drive_protect_config_monitor #(
    parameter int unsigned NUM_BLOCKS = 32
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_hold_reset_b,
    input wire logic i_quad_io_enable,
    input wire logic i_cs_b,
    input wire logic o_so_oe_b,
    input wire logic o_hold_active,
    input wire logic o_reset_active,
    input wire logic o_io3_is_data,
    input wire logic o_wp_active,
    input wire logic [1:0] o_drive_strength,
    input wire logic o_protect_scheme_select,
    input wire logic [NUM_BLOCKS-1:0] o_block_locked,
    input wire logic [7:0] o_config
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    // Role outputs lag one cycle, so the edge leaving reset is skipped.
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    a_quad_data_pins: assert property (
        $past(i_rst_b) && $past(i_quad_io_enable) |->
        !o_hold_active && !o_reset_active && o_io3_is_data && !o_wp_active)
        else $error("quad pins still have control roles");
    a_role_select: assert property (
        $past(i_rst_b, 2) && $past(i_rst_b) && !$past(i_quad_io_enable) && $stable(o_config)
        |-> o_hold_active == !o_config[7] && o_reset_active == o_config[7])
        else $error("pin role does not follow bit 7");
    a_reserved_zero: assert property (
        (o_config & 8'h1b) == 8'h00)
        else $error("reserved config bits not zero");
    a_drive_legal: assert property (
        o_drive_strength != 2'h0)
        else $error("reserved drive code in use");
    a_field_mirror: assert property (
        $stable(o_config) |-> o_drive_strength == o_config[6:5]
        && o_protect_scheme_select == o_config[2])
        else $error("field outputs differ from config");
    a_locks_at_reset: assert property (
        !$past(i_rst_b) |-> &o_block_locked)
        else $error("locks not all set after reset");
    a_pin_relock: assert property (
        $past(i_rst_b) && !i_quad_io_enable && o_config[7] && !i_hold_reset_b
        |-> ##[1:2] &o_block_locked)
        else $error("pin reset did not relock");
    a_unlock_scheme: assert property (
        $past(i_rst_b) && |($past(o_block_locked) & ~o_block_locked)
        |-> $past(o_protect_scheme_select))
        else $error("unlock while range scheme chosen");
    a_unlock_single: assert property (
        $onehot0($past(o_block_locked) & ~o_block_locked))
        else $error("more than one block unlocked at once");
    // A config change or a driven output outside a frame means a stray update.
    a_cfg_in_frame: assert property (
        $changed(o_config) |-> !$past(i_cs_b))
        else $error("config changed outside a frame");
    a_drive_in_frame: assert property (
        !o_so_oe_b |-> !$past(i_cs_b))
        else $error("output driven outside a frame");
    // Main scenarios reached.
    c_unlock: cover property (|($past(o_block_locked) & ~o_block_locked));
    c_reset_role: cover property (o_reset_active);
    c_quad: cover property (o_io3_is_data);
    c_read_drive: cover property (!o_so_oe_b);
endmodule : pin_drive_protect_config_monitor

bind pin_drive_protect_config pin_drive_protect_config_monitor #(.NUM_BLOCKS(NUM_BLOCKS)) mon (
    .i_sys_clk, .i_rst_b, .i_hold_reset_b, .i_quad_io_enable, .i_cs_b, .o_so_oe_b, .o_hold_active,
    .o_reset_active, .o_io3_is_data, .o_wp_active, .o_drive_strength,
    .o_protect_scheme_select, .o_block_locked, .o_config);

/* verification/pin_drive_protect_config_tb_top.sv */
/* Self-checking bench for the pin role, drive and protect register.
   Assumes the host model drives the serial pins; one 100 MHz clock. */
`timescale 1ns/1ns
module pin_drive_protect_config_tb_top;
    // ------------------------------------------------------------------
    // Design, host and helpers
    // ------------------------------------------------------------------
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_hold_reset_b = 1'b1;
    logic i_quad_io_enable = 1'b0;
    logic i_sck, i_cs_b, i_si, o_so, o_hold_active, o_reset_active, o_io3_is_data;
    logic o_wp_active, o_protect_scheme_select, o_so_oe_b, so_line;
    logic oe_seen = 1'b0;
    logic [1:0] o_drive_strength;
    logic [31:0] o_block_locked;
    logic [7:0] o_config, rd;
    logic [15:0] rows [6] = '{16'h2020, 16'hffe4, 16'h4040, 16'h84c4, 16'h1b40, 16'h2424};
    int num_errors = 0;
    int checked = 0;
    // Clock of 10 ns period.
    always #5 i_sys_clk = ~i_sys_clk;
    pin_drive_protect_config DUT (.i_sys_clk, .i_rst_b, .i_sck, .i_cs_b, .i_si,
        .i_hold_reset_b, .i_quad_io_enable, .o_so, .o_so_oe_b, .o_hold_active,
        .o_reset_active, .o_io3_is_data, .o_wp_active, .o_drive_strength,
        .o_protect_scheme_select, .o_block_locked, .o_config);
    // An undriven data line shows the inverse, so a read taken while released fails.
    assign so_line = o_so_oe_b ? ~o_so : o_so;
    spi_host_model host (.i_sys_clk, .i_so(so_line), .o_sck(i_sck), .o_cs_b(i_cs_b), .o_si(i_si));
    // Remembers that the output was driven at least once.
    always @(posedge i_sys_clk) begin
        if (!o_so_oe_b) begin
            oe_seen <= 1'b1;
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic end_of_test();
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    // Lets n edges land, then steps off the edge so outputs are settled.
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : tick
    task automatic cmd(input logic [7:0] op, input logic [23:0] v, input int n);
        host.frame({op, v} >> (32 - n), n, rd);
    endtask : cmd
    task automatic check_reset();
        tick(2);
        chk("reset cfg", o_config, cfg3_pkg::CONFIG_RESET);
        chk("reset locks", o_block_locked, 32'hffffffff);
    endtask : check_reset
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    // Table of writes and their readbacks, then hand-written awkward cases.
    initial begin
        repeat (20) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        check_reset();
        for (int i = 0; i < 6; i++) begin
            cmd(cfg3_pkg::CMD_WRITE_CFG, {rows[i][15:8], 16'h0000}, 16);
            cmd(cfg3_pkg::CMD_READ_CFG, 24'h000000, 16);
            tick(1);
            chk("readback", rd, rows[i][7:0]);
            chk("so released", o_so_oe_b, 1'b1);
            chk("drive", o_drive_strength, rows[i][6:5]);
            chk("scheme", o_protect_scheme_select, rows[i][2]);
            chk("role", {o_hold_active, o_reset_active}, {~rows[i][7], rows[i][7]});
        end
        chk("so driven in read", oe_seen, 1'b1);
        cmd(cfg3_pkg::CMD_BLOCK_UNLOCK, 24'h050000, 32);
        tick(1);
        chk("unlock 5", o_block_locked, ~32'h00000020);
        cmd(cfg3_pkg::CMD_BLOCK_UNLOCK, 24'h1fffff, 32);
        tick(1);
        chk("unlock 31", o_block_locked, ~32'h80000020);
        cmd(cfg3_pkg::CMD_BLOCK_LOCK, 24'h05abcd, 32);
        tick(1);
        chk("lock 5", o_block_locked, ~32'h80000000);
        cmd(cfg3_pkg::CMD_WRITE_CFG, 24'h200000, 16);
        cmd(cfg3_pkg::CMD_BLOCK_UNLOCK, 24'h000000, 32);
        tick(1);
        chk("range scheme", o_block_locked, ~32'h80000000);
        cmd(cfg3_pkg::CMD_WRITE_CFG, 24'ha40000, 16);
        @(posedge i_sys_clk);
        i_quad_io_enable <= 1'b1;
        i_hold_reset_b <= 1'b0;
        tick(3);
        chk("quad pins", {o_hold_active, o_reset_active, o_io3_is_data, o_wp_active}, 4'h2);
        chk("quad no relock", o_block_locked, ~32'h80000000);
        @(posedge i_sys_clk);
        i_quad_io_enable <= 1'b0;
        tick(3);
        chk("pin relock", o_block_locked, 32'hffffffff);
        chk("cfg kept", o_config, 8'ha4);
        @(posedge i_sys_clk);
        i_hold_reset_b <= 1'b1;
        cmd(cfg3_pkg::CMD_BLOCK_UNLOCK, 24'h000000, 32);
        tick(1);
        chk("unlock 0", o_block_locked, ~32'h00000001);
        @(posedge i_sys_clk);
        i_rst_b <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        check_reset();
        // Hold role with the pin low: a whole write frame must be ignored.
        @(posedge i_sys_clk);
        i_hold_reset_b <= 1'b0;
        cmd(cfg3_pkg::CMD_WRITE_CFG, 24'he40000, 16);
        tick(1);
        chk("hold freezes", o_config, cfg3_pkg::CONFIG_RESET);
        chk("hold role", o_hold_active, 1'b1);
        @(posedge i_sys_clk);
        i_hold_reset_b <= 1'b1;
        end_of_test();
    end
    // Guard against a hang.
    initial begin
        repeat (100000) @(posedge i_sys_clk);
        num_errors++;
        end_of_test();
    end
endmodule : pin_drive_protect_config_tb_top

/* verification/spi_host_model.sv */
/* Behavioural SPI host, mode 0, most significant bit first.
   Assumes the shared system clock; each serial clock phase lasts three cycles. */
`timescale 1ns/1ns
module spi_host_model (
    input wire logic i_sys_clk,
    input wire logic i_so,
    output logic o_sck,
    output logic o_cs_b,
    output logic o_si
);
    // ------------------------------------------------------------------
    // Serial frames
    // ------------------------------------------------------------------
    // Idle: deselected, clock low and still.
    initial begin
        o_sck = 1'b0;
        o_cs_b = 1'b1;
        o_si = 1'b0;
    end
    // Sends n bits of d; q keeps the last eight bits seen on rising clocks.
    // Select stays high three cycles after a frame, more than the gap needed.
    task automatic frame(input logic [31:0] d, input int n, output logic [7:0] q);
        q = 8'h00;
        @(posedge i_sys_clk) o_cs_b <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            o_si <= d[i];
            repeat (3) @(posedge i_sys_clk);
            q = {q[6:0], i_so};
            o_sck <= 1'b1;
            repeat (3) @(posedge i_sys_clk);
            o_sck <= 1'b0;
        end
        repeat (3) @(posedge i_sys_clk);
        o_cs_b <= 1'b1;
        o_si <= ~o_si; // A released line must not keep its last value.
        repeat (3) @(posedge i_sys_clk);
    endtask : frame
endmodule : spi_host_model

/* verilog/byte_link_if.sv */
/*
 * Carrier between the serial byte engine and the command decoder.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ns
interface byte_link_if;
    logic byte_done;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic frame_active;
    logic pause;

    modport engine (
        output byte_done,
        output rx_byte,
        output frame_active,
        input tx_byte,
        input pause
    );

    modport decoder (
        input byte_done,
        input rx_byte,
        input frame_active,
        output tx_byte,
        output pause
    );
endinterface : byte_link_if

/* verilog/cfg3_pkg.sv */
/*
 * Constants shared by the third configuration register and its serial
 * byte engine: field positions, reset values, command codes and the
 * block-lock geometry.
 * Assumes the serial link runs well below the system clock.
 */
package cfg3_pkg;

    // ------------------------------------------------------------------
    // Register field layout
    // ------------------------------------------------------------------
    localparam int unsigned PIN_ROLE_BIT = 7;
    localparam int unsigned DRIVE_MSB = 6;
    localparam int unsigned DRIVE_LSB = 5;
    localparam int unsigned SCHEME_BIT = 2;
    localparam logic [7:0] WRITABLE_MASK = 8'he4;
    localparam logic [7:0] CONFIG_RESET = 8'h20;

    // Drive strength codes.
    localparam logic [1:0] DRIVE_RESERVED = 2'h0;
    localparam logic [1:0] DRIVE_FULL = 2'h1;
    localparam logic [1:0] DRIVE_TWO_THIRDS = 2'h2;
    localparam logic [1:0] DRIVE_ONE_THIRD = 2'h3;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_WRITE_CFG = 8'h11;
    localparam logic [7:0] CMD_READ_CFG = 8'h15;
    localparam logic [7:0] CMD_BLOCK_LOCK = 8'h36;
    localparam logic [7:0] CMD_BLOCK_UNLOCK = 8'h39;

    // ------------------------------------------------------------------
    // Block lock geometry
    // ------------------------------------------------------------------
    localparam int unsigned NUM_BLOCKS = 32;
    localparam int unsigned BLOCK_SHIFT = 16;
    localparam logic [1:0] LAST_ADDR_BYTE = 2'h2;
    localparam logic [2:0] LAST_BIT = 3'h7;

endpackage : cfg3_pkg

/* verilog/pin_drive_protect_config.sv */
/*
 * Third configuration register of a serial flash: shared pin role,
 * read drive strength, protection scheme and the per-block lock bits,
 * reached over the serial link by read, write, lock and unlock commands.
 * Assumes the quad I/O enable bit comes from another register and that
 * the serial pins are synchronous to the system clock.
 */
//
// How it works
// R1: Bit 7 picks hold or reset role.
// R2: Role applies only while quad I/O off.
// R3: Quad I/O on: pin is pure data.
// R4: Bits 6:5 set read drive strength.
// R5: Host should tune drive strength for board.
// R6: Bit 2 picks range or block protection.
// R7: All block locks set at any reset.
// R8: Commands 36h/39h lock and unlock blocks.
// R9: Quad I/O on: protect and hold pins data.
// R10: Reserved bits read zero, ignore writes.
`timescale 1ns/1ns
module pin_drive_protect_config #(
    parameter int unsigned NUM_BLOCKS = cfg3_pkg::NUM_BLOCKS,
    parameter int unsigned BLOCK_SHIFT = cfg3_pkg::BLOCK_SHIFT
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_sck,
    input wire logic i_cs_b,
    input wire logic i_si,
    input wire logic i_hold_reset_b,
    input wire logic i_quad_io_enable,
    output logic o_so,
    output logic o_so_oe_b,
    output logic o_hold_active,
    output logic o_reset_active,
    output logic o_io3_is_data,
    output logic o_wp_active,
    output logic [1:0] o_drive_strength,
    output logic o_protect_scheme_select,
    output logic [NUM_BLOCKS-1:0] o_block_locked,
    output logic [7:0] o_config
);

    localparam int unsigned IDX_W = $clog2(NUM_BLOCKS);

    typedef enum logic [4:0] {
        ST_CMD = 5'h01,
        ST_WDATA = 5'h02,
        ST_ADDR = 5'h04,
        ST_RDATA = 5'h08,
        ST_IGNORE = 5'h10
    } dec_state_e;

    byte_link_if bl ();

    dec_state_e state_r;
    dec_state_e state_nxt;
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    logic [23:0] addr_r;
    logic [23:0] addr_nxt;
    logic [1:0] addr_cnt_r;
    logic [1:0] addr_cnt_nxt;
    logic lock_op_r;
    logic lock_op_nxt;
    logic [NUM_BLOCKS-1:0] lock_r;
    logic [NUM_BLOCKS-1:0] lock_nxt;
    logic so_oe_b_r;
    logic so_oe_b_nxt;
    logic [3:0] role_r;
    logic [3:0] role_nxt;
    logic hold_fn;
    logic reset_fn;
    logic dev_rst;
    logic apply_lock;
    logic [23:0] full_addr;
    logic [IDX_W-1:0] blk_idx;

    // ------------------------------------------------------------------
    // Serial byte engine
    // ------------------------------------------------------------------
    serial_byte_engine u_engine (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_sck(i_sck),
        .i_cs_b(i_cs_b),
        .i_si(i_si),
        .o_so(o_so),
        .bl(bl)
    );

    // ------------------------------------------------------------------
    // Shared pin role
    // ------------------------------------------------------------------
    // The pin role bit only counts while quad I/O is off; with quad I/O
    // on, the pin is a data line and neither hold nor reset can act.
    always_comb begin
        hold_fn = ~i_quad_io_enable & ~cfg_r[cfg3_pkg::PIN_ROLE_BIT]; // [R1] [R2] [R3]
        reset_fn = ~i_quad_io_enable & cfg_r[cfg3_pkg::PIN_ROLE_BIT]; // [R1] [R2] [R3]
        dev_rst = reset_fn & ~i_hold_reset_b;
        role_nxt = {hold_fn, reset_fn, i_quad_io_enable, ~i_quad_io_enable}; // [R9]
    end

    // Hold pauses the serial engine; register contents stay untouched.
    assign bl.pause = hold_fn & ~i_hold_reset_b;
    // Reads always return the live register with reserved bits at zero.
    assign bl.tx_byte = cfg_r & cfg3_pkg::WRITABLE_MASK; // [R10]

    // ------------------------------------------------------------------
    // Command decoder and register update
    // ------------------------------------------------------------------
    // Bytes after a completed command are ignored until chip select
    // rises, so a long write frame cannot change the register twice.
    always_comb begin
        state_nxt = state_r;
        cfg_nxt = cfg_r;
        addr_nxt = addr_r;
        addr_cnt_nxt = addr_cnt_r;
        lock_op_nxt = lock_op_r;
        apply_lock = 1'b0;
        full_addr = {addr_r[15:0], bl.rx_byte};
        if (dev_rst || !bl.frame_active) begin
            state_nxt = ST_CMD;
            addr_cnt_nxt = 2'h0;
        end else if (bl.byte_done) begin
            case (state_r)
                ST_CMD: begin
                    addr_cnt_nxt = 2'h0;
                    if (bl.rx_byte == cfg3_pkg::CMD_WRITE_CFG) begin
                        state_nxt = ST_WDATA;
                    end else if (bl.rx_byte == cfg3_pkg::CMD_READ_CFG) begin
                        state_nxt = ST_RDATA;
                    end else if (cfg_r[cfg3_pkg::SCHEME_BIT] &&
                                 (bl.rx_byte == cfg3_pkg::CMD_BLOCK_LOCK ||
                                  bl.rx_byte == cfg3_pkg::CMD_BLOCK_UNLOCK)) begin // [R6] [R8]
                        state_nxt = ST_ADDR;
                        lock_op_nxt = (bl.rx_byte == cfg3_pkg::CMD_BLOCK_LOCK); // [R8]
                    end else begin
                        state_nxt = ST_IGNORE;
                    end
                end
                ST_WDATA: begin
                    // Only the writable bits move; reserved bits stay zero.
                    cfg_nxt = bl.rx_byte & cfg3_pkg::WRITABLE_MASK; // [R1] [R6] [R10]
                    // The reserved drive code is refused; the old strength stays.
                    if (bl.rx_byte[cfg3_pkg::DRIVE_MSB:cfg3_pkg::DRIVE_LSB] ==
                        cfg3_pkg::DRIVE_RESERVED) begin // [R4]
                        cfg_nxt[cfg3_pkg::DRIVE_MSB:cfg3_pkg::DRIVE_LSB] =
                            cfg_r[cfg3_pkg::DRIVE_MSB:cfg3_pkg::DRIVE_LSB];
                    end
                    state_nxt = ST_IGNORE;
                end
                ST_ADDR: begin
                    addr_nxt = full_addr;
                    addr_cnt_nxt = addr_cnt_r + 2'h1;
                    if (addr_cnt_r == cfg3_pkg::LAST_ADDR_BYTE) begin
                        apply_lock = 1'b1; // [R8]
                        state_nxt = ST_IGNORE;
                    end
                end
                ST_RDATA: begin
                    state_nxt = ST_RDATA;
                end
                ST_IGNORE: begin
                    state_nxt = ST_IGNORE;
                end
                default: begin
                    state_nxt = ST_IGNORE;
                end
            endcase
        end
        blk_idx = full_addr[BLOCK_SHIFT +: IDX_W];
        // Output is driven only while a read frame is running.
        so_oe_b_nxt = ~((state_nxt == ST_RDATA) && bl.frame_active);
    end

    // ------------------------------------------------------------------
    // Per-block lock bits
    // ------------------------------------------------------------------
    // A device reset through the shared pin locks every block again, the
    // same as a power-on reset does.
    genvar g;
    generate
        for (g = 0; g < NUM_BLOCKS; g = g + 1) begin : g_lock
            assign lock_nxt[g] = dev_rst ? 1'b1 : // [R7]
                ((apply_lock && blk_idx == IDX_W'(g)) ? lock_op_r : lock_r[g]); // [R8]
        end
    endgenerate

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    // The configuration byte keeps its value over a pin reset; only the
    // power-on reset returns it to its default.
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= ST_CMD;
            cfg_r <= cfg3_pkg::CONFIG_RESET; // [R1] [R4] [R6]
            addr_r <= 24'h000000;
            addr_cnt_r <= 2'h0;
            lock_op_r <= 1'b0;
            lock_r <= '1; // [R7]
            so_oe_b_r <= 1'b1;
            role_r <= 4'h9;
        end else begin
            state_r <= state_nxt;
            cfg_r <= cfg_nxt;
            addr_r <= addr_nxt;
            addr_cnt_r <= addr_cnt_nxt;
            lock_op_r <= lock_op_nxt;
            lock_r <= lock_nxt;
            so_oe_b_r <= so_oe_b_nxt;
            role_r <= role_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The drive field is handed to the pad as written; the host is
    // expected to tune it, since the default suits only a test load.
    assign o_so_oe_b = so_oe_b_r;
    assign o_hold_active = role_r[3];
    assign o_reset_active = role_r[2];
    assign o_io3_is_data = role_r[1]; // [R3] [R9]
    assign o_wp_active = role_r[0]; // [R9]
    assign o_drive_strength = cfg_r[cfg3_pkg::DRIVE_MSB:cfg3_pkg::DRIVE_LSB]; // [R4] [R5]
    assign o_protect_scheme_select = cfg_r[cfg3_pkg::SCHEME_BIT]; // [R6]
    assign o_block_locked = lock_r;
    assign o_config = cfg_r;

endmodule : pin_drive_protect_config

/* verilog/serial_byte_engine.sv */
/*
 * Serial byte engine for SPI mode 0: shifts bytes in on the rising edge
 * of the serial clock and out on the falling edge.
 * Assumes the serial pins are synchronous to the system clock and that
 * each serial clock phase lasts at least two system clock cycles.
 */
`timescale 1ns/1ns
module serial_byte_engine (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_sck,
    input wire logic i_cs_b,
    input wire logic i_si,
    output logic o_so,
    byte_link_if.engine bl
);

    logic sck_q_r;
    logic sck_q_nxt;
    logic [2:0] bit_cnt_r;
    logic [2:0] bit_cnt_nxt;
    logic [7:0] rx_sh_r;
    logic [7:0] rx_sh_nxt;
    logic [7:0] tx_sh_r;
    logic [7:0] tx_sh_nxt;
    logic so_r;
    logic so_nxt;
    logic done_r;
    logic done_nxt;
    logic [7:0] rx_byte_r;
    logic [7:0] rx_byte_nxt;
    logic rise;
    logic fall;

    // ------------------------------------------------------------------
    // Edge detection and shifting
    // ------------------------------------------------------------------
    // A paused link (hold) freezes the shifters but still tracks the
    // clock level, so no false edge appears when the pause ends.
    always_comb begin
        rise = i_sck & ~sck_q_r & ~i_cs_b & ~bl.pause;
        fall = ~i_sck & sck_q_r & ~i_cs_b & ~bl.pause;
        sck_q_nxt = i_sck;
        bit_cnt_nxt = bit_cnt_r;
        rx_sh_nxt = rx_sh_r;
        tx_sh_nxt = tx_sh_r;
        so_nxt = so_r;
        done_nxt = 1'b0;
        rx_byte_nxt = rx_byte_r;
        if (i_cs_b) begin
            bit_cnt_nxt = 3'h0;
        end else if (rise) begin
            rx_sh_nxt = {rx_sh_r[6:0], i_si};
            bit_cnt_nxt = bit_cnt_r + 3'h1;
            if (bit_cnt_r == cfg3_pkg::LAST_BIT) begin
                done_nxt = 1'b1;
                rx_byte_nxt = {rx_sh_r[6:0], i_si};
            end
        end else if (fall) begin
            if (bit_cnt_r == 3'h0) begin
                so_nxt = bl.tx_byte[7];
                tx_sh_nxt = {bl.tx_byte[6:0], 1'b0};
            end else begin
                so_nxt = tx_sh_r[7];
                tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sck_q_r <= 1'b0;
            bit_cnt_r <= 3'h0;
            rx_sh_r <= 8'h00;
            tx_sh_r <= 8'h00;
            so_r <= 1'b0;
            done_r <= 1'b0;
            rx_byte_r <= 8'h00;
        end else begin
            sck_q_r <= sck_q_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            rx_sh_r <= rx_sh_nxt;
            tx_sh_r <= tx_sh_nxt;
            so_r <= so_nxt;
            done_r <= done_nxt;
            rx_byte_r <= rx_byte_nxt;
        end
    end

    // Results toward the decoder.
    assign o_so = so_r;
    assign bl.byte_done = done_r;
    assign bl.rx_byte = rx_byte_r;
    assign bl.frame_active = ~i_cs_b;

endmodule : serial_byte_engine
